// ### shared/rlt_pkg.sv
// Constants, register map and field layout of the reloadable 16-bit timer.
// Assumes a 40 MHz system clock that also serves as the main oscillator input.
// Contract
// R01: Timer counts only while enable bit 7 is 1; enable resets to 0.
// R02: Hardware sets overflow flag bit 6 on overflow; flag resets to 0.
// R03: Width bit 5 set detects overflow out of 16 bits, cleared out of 8.
// R04: Each overflow raises the flag and requests the shared timer interrupt.
// R05: Clock select 000, 001, 010 gives oscillator divided by 32, 64, 128.
// R06: Enable rising from 0 to 1 copies reload value into the counter.
// R07: Every overflow reloads the counter with the 16-bit reload value.
// R08: Count is visible as a low byte and a high byte register.
// R09: Reload low byte feeds count low byte, reload high byte count high byte.
// R10: Enabled counter increments per selected tick; codes 011 to 111 give none.
// R11: Overflow flag stays set until software writes it 0.
package rlt_pkg;

    // ==========================================================
    // Clock and widths
    localparam int unsigned CLK_SYS_HZ = 40_000_000;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 10;
    localparam int unsigned IDX_W      = 8;

    // ==========================================================
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_COUNT_LOW   = 8'h96;
    localparam logic [IDX_W-1:0] IDX_COUNT_HIGH  = 8'h97;
    localparam logic [IDX_W-1:0] IDX_CONTROL     = 8'h9D;
    localparam logic [IDX_W-1:0] IDX_RELOAD_LOW  = 8'h9E;
    localparam logic [IDX_W-1:0] IDX_RELOAD_HIGH = 8'h9F;

    // ==========================================================
    // Control fields
    localparam int unsigned BIT_ENABLE = 7;
    localparam int unsigned BIT_OVF    = 6;
    localparam int unsigned BIT_WIDTH  = 5;
    localparam int unsigned CSEL_LSB   = 0;
    localparam int unsigned CSEL_W     = 3;

    localparam logic [CSEL_W-1:0] CSEL_DIV32  = 3'h0;
    localparam logic [CSEL_W-1:0] CSEL_DIV64  = 3'h1;
    localparam logic [CSEL_W-1:0] CSEL_DIV128 = 3'h2;

    localparam int unsigned DIV32  = 32;
    localparam int unsigned DIV64  = 64;
    localparam int unsigned DIV128 = 128;

    // ==========================================================
    // Reset and fill values
    localparam logic [BYTE_W-1:0] RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0]  RST_COUNT = 16'h0000;
    localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;
    localparam logic [CNT_W-1:0]  CNT_ONES  = 16'hFFFF;

endpackage

// ### src/rlt_count16.sv
// Sixteen-bit counter with reload, byte writes and overflow detection.
// Assumes one controller drives load, write and increment on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rlt_count16
    import rlt_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              load_in,
    input  wire logic [CNT_W-1:0]  reload_in,
    input  wire logic              wr_low_in,
    input  wire logic              wr_high_in,
    input  wire logic [BYTE_W-1:0] wdata_in,
    input  wire logic              inc_in,
    input  wire logic              narrow_in,
    output logic [CNT_W-1:0]       count_out,
    output logic                   wrap_out
);
    // ==========================================================
    // Overflow detection
    always_comb begin
        if (narrow_in) begin
            wrap_out = inc_in && (count_out[BYTE_W-1:0] == BYTE_ONES);  // [R03]
        end else begin
            wrap_out = inc_in && (count_out == CNT_ONES);               // [R03]
        end
    end

    // Reload beats a software byte write that lands on the same edge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            count_out <= RST_COUNT;
        end else if (load_in || wrap_out) begin
            count_out <= reload_in;                                      // [R06] [R07]
        end else if (wr_low_in || wr_high_in) begin
            if (wr_low_in) begin
                count_out[BYTE_W-1:0] <= wdata_in;                       // [R08]
            end
            if (wr_high_in) begin
                count_out[CNT_W-1:BYTE_W] <= wdata_in;                   // [R08]
            end
        end else if (inc_in) begin
            count_out <= count_out + CNT_W'(1);                          // [R10]
        end
    end
endmodule // rlt_count16
`default_nettype wire

// ### src/rlt_prescaler.sv
// Divider that turns the system clock into the counting tick.
// Assumes the select input comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rlt_prescaler
    import rlt_pkg::*;
#(
    parameter int unsigned DIV_W = 7
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              run_in,
    input  wire logic [CSEL_W-1:0] sel_in,
    output logic                   tick_out
);
    // ==========================================================
    // Parameter check
    if ((2 ** DIV_W) < DIV128) begin : g_bad_width
        $error("rlt_prescaler: DIV_W too narrow for largest divide");
    end

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] term;
    logic             valid_sel;

    // ==========================================================
    // Terminal count per select code
    always_comb begin
        valid_sel = 1'b1;
        case (sel_in)
            CSEL_DIV32:  term = DIV_W'(DIV32 - 1);   // [R05]
            CSEL_DIV64:  term = DIV_W'(DIV64 - 1);   // [R05]
            CSEL_DIV128: term = DIV_W'(DIV128 - 1);  // [R05]
            default: begin
                term      = '0;
                valid_sel = 1'b0;                    // [R10]
            end
        endcase
    end

    // Compare with >= so a shorter divide picked mid-count cannot hang
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !run_in || !valid_sel) begin
            cnt      <= '0;
            tick_out <= 1'b0;
        end else if (cnt >= term) begin
            cnt      <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt      <= cnt + DIV_W'(1);
            tick_out <= 1'b0;
        end
    end
endmodule // rlt_prescaler
`default_nettype wire

// ### src/rlt_timer.sv
// Top of the reloadable 16-bit timer: APB slave, control state, assertions.
// Assumes an APB master on clk_sys_in and a consumer of the interrupt pulse.
`timescale 1ns/1ps
`default_nettype none
module rlt_timer
    import rlt_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic [DATA_W-1:0]      prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    output logic                   irq_req_out,
    output logic                   overflow_flag_out
);
    // ==========================================================
    // Control and reload state
    logic                   timer_enable_bit;
    logic                   overflow_flag;
    logic                   overflow_width_select;
    logic [CSEL_W-1:0]      count_clock_select;
    logic [BYTE_W-1:0]      reload_low_byte;
    logic [BYTE_W-1:0]      reload_high_byte;
    logic                   enable_prev;

    // ==========================================================
    // Datapath wires
    logic [CNT_W-1:0]       full_count_value;
    logic                   wrap;
    logic                   tick;
    logic                   start_load;
    logic                   inc;

    // ==========================================================
    // Bus decode
    logic                   setup_phase;
    logic                   access_done;
    logic                   wr_done;
    logic [IDX_W-1:0]       idx;
    logic                   aligned;
    logic                   hit;
    logic [DATA_W-1:0]      rd_word;
    logic                   lane0;
    logic                   wr_count_low;
    logic                   wr_count_high;
    logic                   wr_control;
    logic                   wr_reload_low;
    logic                   wr_reload_high;
    logic [BYTE_W-1:0]      wbyte;

    assign setup_phase = psel_in && !penable_in;
    assign access_done = psel_in && penable_in && pready_out;
    assign wr_done     = access_done && pwrite_in && !pslverr_out;
    assign idx         = paddr_in[ADDR_W-1:2];
    assign aligned     = (paddr_in[1:0] == 2'h0);
    assign lane0       = pstrb_in[0];
    assign wbyte       = pwdata_in[BYTE_W-1:0];

    assign wr_count_low   = wr_done && lane0 && (idx == IDX_COUNT_LOW);
    assign wr_count_high  = wr_done && lane0 && (idx == IDX_COUNT_HIGH);
    assign wr_control     = wr_done && lane0 && (idx == IDX_CONTROL);
    assign wr_reload_low  = wr_done && lane0 && (idx == IDX_RELOAD_LOW);
    assign wr_reload_high = wr_done && lane0 && (idx == IDX_RELOAD_HIGH);

    // Read mux; reserved control bits 4:3 and upper lanes read zero
    always_comb begin
        rd_word = '0;
        hit     = aligned;
        case (idx)
            IDX_COUNT_LOW:   rd_word[BYTE_W-1:0] = full_count_value[BYTE_W-1:0];     // [R08]
            IDX_COUNT_HIGH:  rd_word[BYTE_W-1:0] = full_count_value[CNT_W-1:BYTE_W]; // [R08]
            IDX_CONTROL: begin
                rd_word[BIT_ENABLE]                   = timer_enable_bit;
                rd_word[BIT_OVF]                      = overflow_flag;
                rd_word[BIT_WIDTH]                    = overflow_width_select;
                rd_word[CSEL_LSB+CSEL_W-1:CSEL_LSB]   = count_clock_select;
            end
            IDX_RELOAD_LOW:  rd_word[BYTE_W-1:0] = reload_low_byte;
            IDX_RELOAD_HIGH: rd_word[BYTE_W-1:0] = reload_high_byte;
            default:         hit = 1'b0;
        endcase
    end

    // ==========================================================
    // APB answer: data captured at setup, ready in the first access cycle
    // Read data is a snapshot one cycle before completion, traded for registered outputs
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup_phase;
            if (setup_phase) begin
                prdata_out  <= pwrite_in ? '0 : rd_word;
                pslverr_out <= !hit;
            end else if (access_done) begin
                prdata_out  <= '0;
                pslverr_out <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Control register
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timer_enable_bit      <= 1'b0;                               // [R01]
            overflow_width_select <= 1'b0;                               // [R03]
            count_clock_select    <= CSEL_DIV32;
        end else if (wr_control) begin
            timer_enable_bit      <= pwdata_in[BIT_ENABLE];              // [R01]
            overflow_width_select <= pwdata_in[BIT_WIDTH];               // [R03]
            count_clock_select    <= pwdata_in[CSEL_LSB+CSEL_W-1:CSEL_LSB];
        end
    end

    // Overflow flag: hardware set beats a software clear on the same edge
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            overflow_flag <= 1'b0;                                       // [R02]
        end else if (wrap) begin
            overflow_flag <= 1'b1;                                       // [R02] [R04]
        end else if (wr_control && !pwdata_in[BIT_OVF]) begin
            overflow_flag <= 1'b0;                                       // [R11]
        end
    end

    // Reload value registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reload_low_byte  <= RST_BYTE;
            reload_high_byte <= RST_BYTE;
        end else begin
            if (wr_reload_low) begin
                reload_low_byte <= wbyte;                                // [R09]
            end
            if (wr_reload_high) begin
                reload_high_byte <= wbyte;                               // [R09]
            end
        end
    end

    // ==========================================================
    // Enable edge and interrupt pulse
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            enable_prev <= 1'b0;
        end else begin
            enable_prev <= timer_enable_bit;
        end
    end

    assign start_load = timer_enable_bit && !enable_prev;                // [R06]
    assign inc        = tick && timer_enable_bit;                        // [R01] [R10]

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            irq_req_out       <= 1'b0;
            overflow_flag_out <= 1'b0;
        end else begin
            irq_req_out       <= wrap;                                   // [R04]
            overflow_flag_out <= wrap || (overflow_flag && !(wr_control && !pwdata_in[BIT_OVF]));
        end
    end

    // ==========================================================
    // Datapath
    rlt_prescaler #(
        .DIV_W      (7)
    ) u_prescaler (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .run_in     (timer_enable_bit),
        .sel_in     (count_clock_select),
        .tick_out   (tick)
    );

    rlt_count16 u_count (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .load_in    (start_load),
        .reload_in  ({reload_high_byte, reload_low_byte}),               // [R09]
        .wr_low_in  (wr_count_low),
        .wr_high_in (wr_count_high),
        .wdata_in   (wbyte),
        .inc_in     (inc),
        .narrow_in  (!overflow_width_select),                            // [R03]
        .count_out  (full_count_value),
        .wrap_out   (wrap)
    );

    // ==========================================================
    // Helper: cycles since the last tick, valid only across an undisturbed gap
    logic [7:0]        gap;
    logic              gap_valid;
    logic [CSEL_W-1:0] sel_seen;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !timer_enable_bit) begin
            gap       <= '0;
            gap_valid <= 1'b0;
            sel_seen  <= CSEL_DIV32;
        end else if (count_clock_select != sel_seen) begin
            gap       <= '0;
            gap_valid <= 1'b0;
            sel_seen  <= count_clock_select;
        end else if (tick) begin
            gap       <= 8'h01;
            gap_valid <= 1'b1;
        end else if (gap != 8'hFF) begin
            gap       <= gap + 8'h01;
        end
    end

    function automatic logic [7:0] div_of(input logic [CSEL_W-1:0] s);
        case (s)
            CSEL_DIV32:  div_of = 8'(DIV32);
            CSEL_DIV64:  div_of = 8'(DIV64);
            CSEL_DIV128: div_of = 8'(DIV128);
            default:     div_of = 8'h00;
        endcase
    endfunction

    // ==========================================================
    // Assertions
    sequence s_setup_read(logic [IDX_W-1:0] r);
        setup_phase && !pwrite_in && aligned && (idx == r);
    endsequence

    sequence s_enable_rise;
        timer_enable_bit && !enable_prev;
    endsequence

    a_enable_reset: assert property (@(posedge clk_sys_in)                               // [R01]
        rst_in |=> !timer_enable_bit && !overflow_flag && !overflow_width_select)
        else $error("control bits not zero after reset");

    a_hold_disabled: assert property (@(posedge clk_sys_in) disable iff (rst_in)         // [R01]
        !timer_enable_bit && !wr_count_low && !wr_count_high |=> $stable(full_count_value))
        else $error("count moved while disabled");

    a_flag_on_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)          // [R02]
        wrap |=> overflow_flag && overflow_flag_out)
        else $error("overflow flag not set on overflow");

    a_irq_on_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R04]
        wrap |=> irq_req_out ##1 (!irq_req_out || $past(wrap)))
        else $error("interrupt request not a pulse per overflow");

    a_narrow_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R03]
        inc && !overflow_width_select |-> wrap == (full_count_value[BYTE_W-1:0] == BYTE_ONES))
        else $error("8-bit overflow detection wrong");

    a_wide_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)             // [R03]
        inc && overflow_width_select |-> wrap == (full_count_value == CNT_ONES))
        else $error("16-bit overflow detection wrong");

    a_start_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)            // [R06]
        s_enable_rise |=> full_count_value == $past({reload_high_byte, reload_low_byte}))
        else $error("enable rise did not load reload value");

    a_wrap_reload: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R07]
        wrap |=> full_count_value == $past({reload_high_byte, reload_low_byte}))
        else $error("overflow did not reload counter");

    a_increment: assert property (@(posedge clk_sys_in) disable iff (rst_in)             // [R10]
        inc && !wrap && !start_load && !wr_count_low && !wr_count_high
        |=> full_count_value == $past(full_count_value) + CNT_W'(1))
        else $error("count did not advance by one on tick");

    a_tick_period: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R05]
        tick && gap_valid && (count_clock_select == sel_seen) && $past(timer_enable_bit)
        |-> gap == div_of(count_clock_select))
        else $error("tick spacing does not match clock select");

    a_reserved_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in)         // [R10]
        (div_of(count_clock_select) == 8'h00) |=> !tick)
        else $error("tick seen on reserved clock select");

    a_flag_sticky: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R11]
        overflow_flag && !wr_control |=> overflow_flag)
        else $error("overflow flag cleared without software write");

    a_read_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)              // [R08]
        s_setup_read(IDX_COUNT_LOW) |=> pready_out && !pslverr_out
            && prdata_out == {24'h000000, $past(full_count_value[BYTE_W-1:0])})
        else $error("low count byte read wrong");

    a_read_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)             // [R08]
        s_setup_read(IDX_COUNT_HIGH) |=> prdata_out == {24'h000000, $past(full_count_value[CNT_W-1:BYTE_W])})
        else $error("high count byte read wrong");

    a_ready_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R08]
        pready_out |=> !pready_out)
        else $error("ready held longer than one access cycle");

    a_unmapped_error: assert property (@(posedge clk_sys_in) disable iff (rst_in)        // [R08]
        setup_phase && !hit |=> pready_out && pslverr_out && prdata_out == 32'h00000000)
        else $error("unmapped access not refused");

    a_refused_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)         // [R09]
        access_done && pslverr_out
        |=> $stable(timer_enable_bit) && $stable(count_clock_select) && $stable({reload_high_byte, reload_low_byte}))
        else $error("refused write changed a register");

    a_read_control: assert property (@(posedge clk_sys_in) disable iff (rst_in)          // [R01] [R02] [R03]
        s_setup_read(IDX_CONTROL) |=> prdata_out == {24'h000000, $past(timer_enable_bit), $past(overflow_flag),
            $past(overflow_width_select), 2'h0, $past(count_clock_select)})
        else $error("control register read wrong");

    a_read_reload_low: assert property (@(posedge clk_sys_in) disable iff (rst_in)       // [R09]
        s_setup_read(IDX_RELOAD_LOW) |=> prdata_out == {24'h000000, $past(reload_low_byte)})
        else $error("reload low byte read wrong");

    a_read_reload_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)      // [R09]
        s_setup_read(IDX_RELOAD_HIGH) |=> prdata_out == {24'h000000, $past(reload_high_byte)})
        else $error("reload high byte read wrong");

    a_enable_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)          // [R01] [R05]
        wr_control |=> timer_enable_bit == $past(pwdata_in[BIT_ENABLE])
            && count_clock_select == $past(pwdata_in[CSEL_LSB+CSEL_W-1:CSEL_LSB]))
        else $error("control write did not land");

    a_flag_clear: assert property (@(posedge clk_sys_in) disable iff (rst_in)            // [R11]
        overflow_flag && wr_control && !pwdata_in[BIT_OVF] && !wrap |=> !overflow_flag)
        else $error("software clear of overflow flag ignored");

    a_irq_only_wrap: assert property (@(posedge clk_sys_in) disable iff (rst_in)         // [R04]
        !wrap |=> !irq_req_out)
        else $error("interrupt request without overflow");

    a_flag_mirror: assert property (@(posedge clk_sys_in) disable iff (rst_in)           // [R02]
        overflow_flag_out == overflow_flag)
        else $error("overflow flag output differs from flag");

endmodule // rlt_timer
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the reloadable 16-bit timer, driven over APB.
// Assumes rlt_timer raises pready for every access; the bench waits for it under a watchdog.
`timescale 1ns/1ps
`default_nettype none
module tb
    import rlt_pkg::*;
;
    logic              clk_sys_in;
    logic              rst_in;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [3:0]        pstrb;
    logic [DATA_W-1:0] prdata_out;
    logic              pready_out;
    logic              pslverr_out;
    logic              irq_req_out;
    logic              overflow_flag_out;
    int                failures;
    int                n_compared;
    int                cyc = 0;

    rlt_timer dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .irq_req_out(irq_req_out), .overflow_flag_out(overflow_flag_out)
    );

    // ==========================================================
    // Clock, cycle count, watchdog
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) cyc <= cyc + 1;
    // Whole run is under two thousand cycles; the 40000-cycle limit leaves wide margin
    initial begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end

    // ==========================================================
    // Checking and APB tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Pready is sampled at the rising edge itself; the request stands unchanged until then
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rdat, output logic err);
        @(posedge clk_sys_in);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h000000, wd};
        @(posedge clk_sys_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys_in);
        end while (pready_out !== 1'b1);
        rdat = prdata_out;
        err  = pslverr_out;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        check(r, {24'h000000, exp});
    endtask

    task automatic wait_irq(input int lim, output logic seen);
        seen = 1'b0;
        repeat (lim) begin
            @(negedge clk_sys_in);
            if (irq_req_out === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic        e;
        logic        w;
        logic        got;
        logic [15:0] rel;
        logic [7:0]  ctl;
        int          div;
        int          t0;
        failures = 0;
        n_compared = 0;
        rst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h1;
        repeat (16) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(IDX_CONTROL, 8'h00);
        rd(IDX_COUNT_LOW, 8'h00);
        rd(IDX_RELOAD_HIGH, 8'h00);
        rd(IDX_RELOAD_LOW, 8'h00);
        apb(1'b0, 8'h98, 8'h00, r, e);
        check({31'h0, e}, 32'h00000001);
        check(r, 32'h00000000);
        wr(IDX_COUNT_LOW, 8'h5A);
        wr(IDX_COUNT_HIGH, 8'hA5);
        repeat (100) @(posedge clk_sys_in);
        rd(IDX_COUNT_LOW, 8'h5A);
        rd(IDX_COUNT_HIGH, 8'hA5);
        // One pass per documented clock code; width alternates 16, 8, 16
        for (int i = 0; i < 3; i++) begin
            w   = (i == 1) ? 1'b0 : 1'b1;
            rel = w ? 16'hFFFE : 16'h34FE;
            div = 32 << i;
            ctl = {1'b1, 1'b0, w, 2'b00, i[2:0]};
            wr(IDX_RELOAD_LOW, rel[7:0]);
            wr(IDX_RELOAD_HIGH, rel[15:8]);
            wr(IDX_CONTROL, ctl);
            t0 = cyc;
            rd(IDX_COUNT_LOW, rel[7:0]);
            rd(IDX_COUNT_HIGH, rel[15:8]);
            wait_irq(600, got);
            check({31'h0, got}, 32'h00000001);
            check({31'h0, (cyc - t0 >= 2 * div - 4) && (cyc - t0 <= 2 * div + 8)}, 32'h00000001);
            rd(IDX_COUNT_LOW, rel[7:0]);
            rd(IDX_COUNT_HIGH, rel[15:8]);
            check({31'h0, overflow_flag_out}, 32'h00000001);
            rd(IDX_CONTROL, ctl | 8'h40);
            wr(IDX_CONTROL, ctl | 8'h40);
            rd(IDX_CONTROL, ctl | 8'h40);
            wr(IDX_CONTROL, 8'h00);
            rd(IDX_CONTROL, 8'h00);
            check({31'h0, overflow_flag_out}, 32'h00000000);
        end
        // Disabled timer holds its count
        apb(1'b0, IDX_COUNT_LOW, 8'h00, r, e);
        repeat (300) @(posedge clk_sys_in);
        rd(IDX_COUNT_LOW, r[7:0]);
        // Reserved clock code gives no tick
        wr(IDX_CONTROL, 8'h83);
        wait_irq(400, got);
        check({31'h0, got}, 32'h00000000);
        rd(IDX_COUNT_LOW, 8'hFE);
        // Mid-run reset while enabled must clear control and count again
        @(posedge clk_sys_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        rd(IDX_CONTROL, 8'h00);
        rd(IDX_COUNT_HIGH, 8'h00);
        tally_and_finish();
    end

endmodule // tb
`default_nettype wire
